// ===== rtl/pdeg_pkg.sv
// Constants for the port D / port E general-purpose I/O block.
// Assumes an AXI4-Lite master with 32-bit data and byte addressing.
package pdeg_pkg;
  // ==========================================================
  // Widths
  localparam int PDEG_PD_W = 8;
  localparam int PDEG_PE_W = 6;
  localparam int PDEG_SPI_W = 4;
  localparam int PDEG_AW = 8;
  localparam int PDEG_DW = 32;

  // ==========================================================
  // Register indices; the byte address is four times the index
  localparam logic [5:0] PDEG_PD_DATA_IDX = 6'h03;
  localparam logic [5:0] PDEG_PD_DIR_IDX = 6'h07;
  localparam logic [5:0] PDEG_PE_DATA_IDX = 6'h08;
  localparam logic [5:0] PDEG_PE_DIR_IDX = 6'h0C;
  localparam logic [5:0] PDEG_PD_PULL_IDX = 6'h0F;
  localparam logic [7:0] PDEG_PD_DATA_ADDR = {PDEG_PD_DATA_IDX, 2'h0};
  localparam logic [7:0] PDEG_PD_DIR_ADDR = {PDEG_PD_DIR_IDX, 2'h0};
  localparam logic [7:0] PDEG_PE_DATA_ADDR = {PDEG_PE_DATA_IDX, 2'h0};
  localparam logic [7:0] PDEG_PE_DIR_ADDR = {PDEG_PE_DIR_IDX, 2'h0};
  localparam logic [7:0] PDEG_PD_PULL_ADDR = {PDEG_PD_PULL_IDX, 2'h0};

  // ==========================================================
  // Reset values
  localparam logic [7:0] PDEG_PD_DIR_RST = 8'h00;
  localparam logic [7:0] PDEG_PD_PULL_RST = 8'h00;
  localparam logic [5:0] PDEG_PE_DIR_RST = 6'h00;
  localparam logic [7:0] PDEG_PD_OE_N_RST = 8'hFF;
  localparam logic [5:0] PDEG_PE_OE_N_RST = 6'h3F;
  localparam logic [7:0] PDEG_PD_OUT_RST = 8'h00;
  localparam logic [5:0] PDEG_PE_OUT_RST = 6'h00;

  // ==========================================================
  // Serial pin sharing on port E
  localparam int PDEG_PE_TX_BIT = 0;
  localparam int PDEG_PE_RX_BIT = 1;
  localparam logic [5:0] PDEG_PE_SERIAL_MASK = 6'h03;
  localparam logic PDEG_RX_IDLE = 1'h1;

  // ==========================================================
  // Bus responses
  localparam logic [1:0] PDEG_RESP_OKAY = 2'h0;
  localparam logic [1:0] PDEG_RESP_SLVERR = 2'h2;
endpackage : pdeg_pkg

// ===== rtl/pdeg_sync.sv
// Two-flop synchroniser for a vector of pin levels.
// Assumes each bit is an independent level; no bus coherence.
`timescale 1ns/1ps
module pdeg_sync #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta;

  // ==========================================================
  // Stage one feeds only stage two
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta <= '0;
      sync_out <= '0;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end
endmodule : pdeg_sync

// ===== rtl/pdeg_top.sv
// Port D (8 pins, pullups, shared with SPI) and port E (6 pins, two shared
// with the serial module) general-purpose I/O with an AXI4-Lite slave.
// Assumes SPI and serial control signals arrive on aclk; pins are async.
//
// Functional notes
// - Port D direction 1 enables pin driver
// - Reset clears all port D directions
// - Port D read: latch if output, else pin
// - Data latches always writable, input pins unaffected
// - Pullup only when enabled and input
// - Output direction disconnects pullup automatically
// - Eight pullup enable bits at index 0x0F
// - Reset clears all pullup enables
// - Port E has six bits only
// - Reset makes port E inputs; 1 drives
// - Reset leaves data latches untouched
// - Port E read: latch if output, else pin
// - Serial ownership overrides port E direction driver
// - Port E bit 1 feeds serial receive
// - Port E bit 0 driven by serial transmit
// - SPI ownership overrides port D direction driver
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module pdeg_top
  import pdeg_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [PDEG_AW-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [PDEG_DW-1:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [PDEG_AW-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [PDEG_DW-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [PDEG_PD_W-1:0] pd_in,
  output logic [PDEG_PD_W-1:0] pd_out,
  output logic [PDEG_PD_W-1:0] pd_oe_n,
  output logic [PDEG_PD_W-1:0] pd_pullup,
  input wire logic [PDEG_PE_W-1:0] pe_in,
  output logic [PDEG_PE_W-1:0] pe_out,
  output logic [PDEG_PE_W-1:0] pe_oe_n,
  input wire logic [PDEG_SPI_W-1:0] spi_pin_own,
  input wire logic [PDEG_SPI_W-1:0] spi_pin_drive,
  input wire logic [PDEG_SPI_W-1:0] spi_pin_out,
  output logic [PDEG_SPI_W-1:0] spi_pin_in,
  input wire logic serial_module_enable,
  input wire logic serial_txd,
  output logic serial_rxd
);
  logic [PDEG_PD_W-1:0] port_d_latch;
  logic [PDEG_PD_W-1:0] port_d_dir;
  logic [PDEG_PD_W-1:0] port_d_pull_en;
  logic [PDEG_PE_W-1:0] port_e_latch;
  logic [PDEG_PE_W-1:0] port_e_dir;
  logic [PDEG_PD_W-1:0] pd_sync;
  logic [PDEG_PE_W-1:0] pe_sync;
  logic aw_held, w_held;
  logic [PDEG_AW-1:0] awaddr_q;
  logic [PDEG_DW-1:0] wdata_q;
  logic [3:0] wstrb_q;
  logic aw_fire, w_fire, ar_fire, do_write, wr_byte;
  logic next_aw_held, next_w_held, next_bvalid, next_rvalid;
  logic wr_pd_data, wr_pd_dir, wr_pe_data, wr_pe_dir, wr_pd_pull, wr_mapped;
  logic [PDEG_PD_W-1:0] next_port_d_latch, next_port_d_dir, next_port_d_pull_en;
  logic [PDEG_PE_W-1:0] next_port_e_latch, next_port_e_dir;
  logic [PDEG_PD_W-1:0] pd_own, pd_spi_drv, pd_spi_val;
  logic [PDEG_PD_W-1:0] next_pd_drv, next_pd_val;
  logic [PDEG_PE_W-1:0] pe_own, next_pe_drv, next_pe_val;
  logic [PDEG_PD_W-1:0] pd_view;
  logic [PDEG_PE_W-1:0] pe_view;
  logic [PDEG_DW-1:0] rd_word;
  logic rd_mapped;

  // ==========================================================
  // Pin synchronisers
  pdeg_sync #(.W(PDEG_PD_W)) u_pd_sync (
    .clk(aclk),
    .rst_n(aresetn),
    .async_in(pd_in),
    .sync_out(pd_sync)
  );

  pdeg_sync #(.W(PDEG_PE_W)) u_pe_sync (
    .clk(aclk),
    .rst_n(aresetn),
    .async_in(pe_in),
    .sync_out(pe_sync)
  );

  // ==========================================================
  // Bus handshake and write decode
  always_comb begin
    aw_fire = awvalid & awready;
    w_fire = wvalid & wready;
    ar_fire = arvalid & arready;
    do_write = aw_held & w_held;
    next_aw_held = (aw_held | aw_fire) & ~do_write;
    next_w_held = (w_held | w_fire) & ~do_write;
    next_bvalid = do_write | (bvalid & ~bready);
    next_rvalid = ar_fire | (rvalid & ~rready);
    wr_byte = do_write & wstrb_q[0];
    wr_pd_data = wr_byte & (awaddr_q == PDEG_PD_DATA_ADDR);
    wr_pd_dir = wr_byte & (awaddr_q == PDEG_PD_DIR_ADDR);
    wr_pe_data = wr_byte & (awaddr_q == PDEG_PE_DATA_ADDR);
    wr_pe_dir = wr_byte & (awaddr_q == PDEG_PE_DIR_ADDR);
    wr_pd_pull = wr_byte & (awaddr_q == PDEG_PD_PULL_ADDR);
    wr_mapped = (awaddr_q == PDEG_PD_DATA_ADDR) | (awaddr_q == PDEG_PD_DIR_ADDR) |
                (awaddr_q == PDEG_PE_DATA_ADDR) | (awaddr_q == PDEG_PE_DIR_ADDR) |
                (awaddr_q == PDEG_PD_PULL_ADDR);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'h0;
      w_held <= 1'h0;
      awready <= 1'h0;
      wready <= 1'h0;
      bvalid <= 1'h0;
      bresp <= PDEG_RESP_OKAY;
    end else begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      awready <= ~next_aw_held & ~next_bvalid;
      wready <= ~next_w_held & ~next_bvalid;
      bvalid <= next_bvalid;
      if (do_write) begin
        bresp <= wr_mapped ? PDEG_RESP_OKAY : PDEG_RESP_SLVERR;
      end
    end
  end

  // Request payloads are held until the write is performed
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= 4'h0;
    end else begin
      if (aw_fire) begin
        awaddr_q <= awaddr;
      end
      if (w_fire) begin
        wdata_q <= wdata;
        wstrb_q <= wstrb;
      end
    end
  end

  // ==========================================================
  // Register next values
  always_comb begin
    next_port_d_latch = wr_pd_data ? wdata_q[PDEG_PD_W-1:0] : port_d_latch;
    next_port_e_latch = wr_pe_data ? wdata_q[PDEG_PE_W-1:0] : port_e_latch;
    next_port_d_dir = wr_pd_dir ? wdata_q[PDEG_PD_W-1:0] : port_d_dir;
    next_port_e_dir = wr_pe_dir ? wdata_q[PDEG_PE_W-1:0] : port_e_dir;
    next_port_d_pull_en = wr_pd_pull ? wdata_q[PDEG_PD_W-1:0] : port_d_pull_en;
  end

  // Data latches have no reset
  always_ff @(posedge aclk) begin
    port_d_latch <= next_port_d_latch;
    port_e_latch <= next_port_e_latch;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_d_dir <= PDEG_PD_DIR_RST;
      port_e_dir <= PDEG_PE_DIR_RST;
      port_d_pull_en <= PDEG_PD_PULL_RST;
    end else begin
      port_d_dir <= next_port_d_dir;
      port_e_dir <= next_port_e_dir;
      port_d_pull_en <= next_port_d_pull_en;
    end
  end

  // ==========================================================
  // Pin drivers; computed from next values so pins follow the write edge
  always_comb begin
    pd_own = {{(PDEG_PD_W-PDEG_SPI_W){1'h0}}, spi_pin_own};
    pd_spi_drv = {{(PDEG_PD_W-PDEG_SPI_W){1'h0}}, spi_pin_drive};
    pd_spi_val = {{(PDEG_PD_W-PDEG_SPI_W){1'h0}}, spi_pin_out};
    next_pd_drv = (pd_own & pd_spi_drv) | (~pd_own & next_port_d_dir);
    next_pd_val = (pd_own & pd_spi_val) | (~pd_own & next_port_d_dir & next_port_d_latch);
    pe_own = serial_module_enable ? PDEG_PE_SERIAL_MASK : 6'h00;
    next_pe_drv = ~pe_own & next_port_e_dir;
    next_pe_val = ~pe_own & next_port_e_dir & next_port_e_latch;
    if (serial_module_enable) begin
      next_pe_drv[PDEG_PE_TX_BIT] = 1'h1;
      next_pe_val[PDEG_PE_TX_BIT] = serial_txd;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pd_oe_n <= PDEG_PD_OE_N_RST;
      pd_out <= PDEG_PD_OUT_RST;
      pd_pullup <= PDEG_PD_PULL_RST;
      pe_oe_n <= PDEG_PE_OE_N_RST;
      pe_out <= PDEG_PE_OUT_RST;
    end else begin
      pd_oe_n <= ~next_pd_drv;
      pd_out <= next_pd_val;
      pd_pullup <= next_port_d_pull_en & ~next_port_d_dir & ~next_pd_drv;
      pe_oe_n <= ~next_pe_drv;
      pe_out <= next_pe_val;
    end
  end

  // Peripheral receive paths
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      serial_rxd <= PDEG_RX_IDLE;
      spi_pin_in <= '0;
    end else begin
      serial_rxd <= serial_module_enable ? pe_sync[PDEG_PE_RX_BIT] : PDEG_RX_IDLE;
      spi_pin_in <= pd_sync[PDEG_SPI_W-1:0];
    end
  end

  // ==========================================================
  // Read path
  always_comb begin
    pd_view = (port_d_dir & port_d_latch) | (~port_d_dir & pd_sync);
    pe_view = (port_e_dir & port_e_latch) | (~port_e_dir & pe_sync);
    rd_word = '0;
    rd_mapped = 1'h1;
    unique case (araddr)
      PDEG_PD_DATA_ADDR: rd_word = {{(PDEG_DW-PDEG_PD_W){1'h0}}, pd_view};
      PDEG_PD_DIR_ADDR: rd_word = {{(PDEG_DW-PDEG_PD_W){1'h0}}, port_d_dir};
      PDEG_PE_DATA_ADDR: rd_word = {{(PDEG_DW-PDEG_PE_W){1'h0}}, pe_view};
      PDEG_PE_DIR_ADDR: rd_word = {{(PDEG_DW-PDEG_PE_W){1'h0}}, port_e_dir};
      PDEG_PD_PULL_ADDR: rd_word = {{(PDEG_DW-PDEG_PD_W){1'h0}}, port_d_pull_en};
      default: rd_mapped = 1'h0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'h0;
      rvalid <= 1'h0;
      rdata <= '0;
      rresp <= PDEG_RESP_OKAY;
    end else begin
      arready <= ~next_rvalid;
      rvalid <= next_rvalid;
      if (ar_fire) begin
        rdata <= rd_word;
        rresp <= rd_mapped ? PDEG_RESP_OKAY : PDEG_RESP_SLVERR;
      end
    end
  end

  // ==========================================================
  // Assertions
  reset_clears_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(!aresetn) |-> (port_d_dir == 8'h00) && (port_e_dir == 6'h00) &&
      (port_d_pull_en == 8'h00) && (pd_pullup == 8'h00))
    else $error("control registers not cleared by reset");

  pd_driver_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(aresetn) |-> pd_oe_n ==
      ~(($past(pd_own) & $past(pd_spi_drv)) | (~$past(pd_own) & port_d_dir)))
    else $error("port D driver enable wrong");

  pullup_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
    pd_pullup == (port_d_pull_en & ~port_d_dir & pd_oe_n))
    else $error("pullup connected while output or disabled");

  pd_readback_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (ar_fire && araddr == PDEG_PD_DATA_ADDR) |=> rvalid &&
      rdata == {24'h000000, $past(pd_view)} &&
      rdata[7:0] == (($past(port_d_dir) & $past(port_d_latch)) |
        (~$past(port_d_dir) & $past(pd_sync))))
    else $error("port D read mux wrong");

  pe_readback_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (ar_fire && araddr == PDEG_PE_DATA_ADDR) |=> rvalid && rdata[31:6] == 26'h0 &&
      rdata[5:0] == (($past(port_e_dir) & $past(port_e_latch)) |
        (~$past(port_e_dir) & $past(pe_sync))))
    else $error("port E read mux wrong");

  latch_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_pd_data |=> port_d_latch == $past(wdata_q[7:0]) && bvalid)
    else $error("port D latch write lost");

  serial_tx_a: assert property (@(posedge aclk) disable iff (!aresetn)
    serial_module_enable |=> !pe_oe_n[0] && pe_out[0] == $past(serial_txd) &&
      pe_oe_n[1])
    else $error("serial transmit pin not owned");

  serial_rx_a: assert property (@(posedge aclk) disable iff (!aresetn)
    serial_module_enable |=> serial_rxd == $past(pe_sync[1]))
    else $error("serial receive path wrong");

  gpio_e_drive_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (!serial_module_enable && $past(aresetn)) |=>
      pe_oe_n == ~port_e_dir && pe_out == (port_e_dir & port_e_latch))
    else $error("port E gpio driver wrong");

  write_resp_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (aw_held && w_held) |=> bvalid ##0 (!awready && !wready))
    else $error("write response not raised");

  pd_write_c: cover property (@(posedge aclk) disable iff (!aresetn) wr_pd_data);
  pe_read_c: cover property (@(posedge aclk) disable iff (!aresetn)
    ar_fire && araddr == PDEG_PE_DATA_ADDR);
  serial_on_c: cover property (@(posedge aclk) disable iff (!aresetn)
    serial_module_enable ##1 !pe_oe_n[0]);
  pullup_on_c: cover property (@(posedge aclk) disable iff (!aresetn) pd_pullup != 8'h00);
endmodule : pdeg_top

// ===== tb/pdeg_pins.sv
// Pin model: outside drivers and floating lines of ports D and E, internal pullups of port D.
// Assumes pin outputs and enables come straight from the GPIO block.
`timescale 1ns/1ps
module pdeg_pins
  import pdeg_pkg::*;
(
  input wire logic aclk,
  input wire logic [PDEG_PD_W-1:0] pd_out,
  input wire logic [PDEG_PD_W-1:0] pd_oe_n,
  input wire logic [PDEG_PD_W-1:0] pd_pullup,
  input wire logic [PDEG_PE_W-1:0] pe_out,
  input wire logic [PDEG_PE_W-1:0] pe_oe_n,
  input wire logic [PDEG_PD_W-1:0] ext_d_en,
  input wire logic [PDEG_PD_W-1:0] ext_d_val,
  input wire logic [PDEG_PE_W-1:0] ext_e_en,
  input wire logic [PDEG_PE_W-1:0] ext_e_val,
  output logic [PDEG_PD_W-1:0] pd_in,
  output logic [PDEG_PE_W-1:0] pe_in
);
  // A line nobody drives changes every cycle
  logic flt = 1'b0;
  always @(posedge aclk) begin
    flt <= ~flt;
  end
  always_comb begin
    for (int i = 0; i < PDEG_PD_W; i++) begin
      if (!pd_oe_n[i]) pd_in[i] = pd_out[i];
      else if (ext_d_en[i]) pd_in[i] = ext_d_val[i];
      else if (pd_pullup[i]) pd_in[i] = 1'b1;
      else pd_in[i] = flt;
    end
    for (int j = 0; j < PDEG_PE_W; j++) begin
      if (!pe_oe_n[j]) pe_in[j] = pe_out[j];
      else if (ext_e_en[j]) pe_in[j] = ext_e_val[j];
      else pe_in[j] = flt;
    end
  end
endmodule : pdeg_pins

// ===== tb/pdeg_top_bench.sv
// Self-checking bench for the port D / port E GPIO block.
// Assumes the pin model pdeg_pins and an AXI4-Lite master written here.
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin n_tests++; if ((got) !== (exp)) begin bad_count++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got); end end
module pdeg_top_bench
  import pdeg_pkg::*;
;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [3:0] spi_pin_own = 4'h0;
  logic [3:0] spi_pin_drive = 4'h0;
  logic [3:0] spi_pin_out = 4'h0;
  logic serial_module_enable = 1'b0;
  logic serial_txd = 1'b1;
  logic [7:0] ext_d_en = 8'h00;
  logic [7:0] ext_d_val = 8'h00;
  logic [5:0] ext_e_en = 6'h00;
  logic [5:0] ext_e_val = 6'h00;
  logic awready, wready, bvalid, arready, rvalid, serial_rxd;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [7:0] pd_in, pd_out, pd_oe_n, pd_pullup;
  logic [5:0] pe_in, pe_out, pe_oe_n;
  logic [3:0] spi_pin_in;
  int bad_count = 0;
  int n_tests = 0;

  pdeg_top u_pdeg_top (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .pd_in(pd_in), .pd_out(pd_out), .pd_oe_n(pd_oe_n), .pd_pullup(pd_pullup),
    .pe_in(pe_in), .pe_out(pe_out), .pe_oe_n(pe_oe_n), .spi_pin_own(spi_pin_own),
    .spi_pin_drive(spi_pin_drive), .spi_pin_out(spi_pin_out), .spi_pin_in(spi_pin_in),
    .serial_module_enable(serial_module_enable), .serial_txd(serial_txd),
    .serial_rxd(serial_rxd));
  pdeg_pins u_pdeg_pins (.aclk(aclk), .pd_out(pd_out), .pd_oe_n(pd_oe_n),
    .pd_pullup(pd_pullup), .pe_out(pe_out), .pe_oe_n(pe_oe_n), .ext_d_en(ext_d_en),
    .ext_d_val(ext_d_val), .ext_e_en(ext_e_en), .ext_e_val(ext_e_val), .pd_in(pd_in),
    .pe_in(pe_in));

  // ==========================================================
  // Bus master
  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : summarize
  task automatic bail(input int i);
    if (i >= 200) begin
      bad_count++;
      $display("CHECK FAILED bus answer expected within 200 seen none");
      summarize();
    end
  endtask : bail
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
    #1;
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
    int i;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 200; i++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    r = bresp;
    bready <= 1'b0;
    bail(i);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int i;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 200; i++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    bail(i);
  endtask : rd
  task automatic wchk(input logic [7:0] a, input logic [7:0] d);
    logic [1:0] r;
    wr(a, d, r);
    `CHK("bresp", PDEG_RESP_OKAY, r);
  endtask : wchk
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    `CHK(nm, e, d);
    `CHK("rresp", PDEG_RESP_OKAY, r);
  endtask : rchk

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    cyc(1);
    `CHK("pd_oe_n", 8'hFF, pd_oe_n);
    `CHK("pe_oe_n", 6'h3F, pe_oe_n);
    `CHK("pd_pullup", 8'h00, pd_pullup);
    rchk("pd dir", PDEG_PD_DIR_ADDR, 32'h0);
    rchk("pull en", PDEG_PD_PULL_ADDR, 32'h0);
    rchk("pe dir", PDEG_PE_DIR_ADDR, 32'h0);
  endtask : t_reset
  task automatic t_port_d();
    ext_d_en <= 8'h0F;
    ext_d_val <= 8'h0C;
    wchk(PDEG_PD_DATA_ADDR, 8'hA5);
    wchk(PDEG_PD_DIR_ADDR, 8'hFF);
    cyc(2);
    `CHK("pd_oe_n", 8'h00, pd_oe_n);
    `CHK("pd_out", 8'hA5, pd_out);
    rchk("pd data", PDEG_PD_DATA_ADDR, 32'hA5);
    wchk(PDEG_PD_DIR_ADDR, 8'hF0);
    cyc(3);
    `CHK("pd_oe_n", 8'h0F, pd_oe_n);
    rchk("pd mixed", PDEG_PD_DATA_ADDR, 32'hAC);
    wchk(PDEG_PD_DATA_ADDR, 8'h5A);
    cyc(2);
    `CHK("pd_out", 8'h50, pd_out);
    rchk("pd input", PDEG_PD_DATA_ADDR, 32'h5C);
  endtask : t_port_d
  task automatic t_pull();
    ext_d_en <= 8'h00;
    wchk(PDEG_PD_PULL_ADDR, 8'hFF);
    cyc(3);
    `CHK("pd_pullup", 8'h0F, pd_pullup);
    rchk("pull en", PDEG_PD_PULL_ADDR, 32'hFF);
    rchk("pd pulled", PDEG_PD_DATA_ADDR, 32'h5F);
    wchk(PDEG_PD_PULL_ADDR, 8'h15);
    wchk(PDEG_PD_DIR_ADDR, 8'h00);
    cyc(2);
    `CHK("pd_pullup", 8'h15, pd_pullup);
    wchk(PDEG_PD_DIR_ADDR, 8'h10);
    cyc(2);
    `CHK("pd_pullup", 8'h05, pd_pullup);
    wchk(PDEG_PD_DIR_ADDR, 8'h00);
    wchk(PDEG_PD_PULL_ADDR, 8'h00);
  endtask : t_pull
  task automatic t_port_e();
    ext_e_en <= 6'h3F;
    ext_e_val <= 6'h2A;
    wchk(PDEG_PE_DATA_ADDR, 8'hFF);
    wchk(PDEG_PE_DIR_ADDR, 8'hFF);
    cyc(2);
    `CHK("pe_oe_n", 6'h00, pe_oe_n);
    `CHK("pe_out", 6'h3F, pe_out);
    rchk("pe dir", PDEG_PE_DIR_ADDR, 32'h3F);
    rchk("pe data", PDEG_PE_DATA_ADDR, 32'h3F);
    wchk(PDEG_PE_DIR_ADDR, 8'h07);
    cyc(3);
    `CHK("pe_oe_n", 6'h38, pe_oe_n);
    rchk("pe mixed", PDEG_PE_DATA_ADDR, 32'h2F);
  endtask : t_port_e
  task automatic t_serial();
    wchk(PDEG_PE_DIR_ADDR, 8'h00);
    ext_e_en <= 6'h3E;
    serial_txd <= 1'b0;
    serial_module_enable <= 1'b1;
    cyc(4);
    `CHK("tx oe", 1'b0, pe_oe_n[0]);
    `CHK("tx out", 1'b0, pe_out[0]);
    `CHK("rx oe", 1'b1, pe_oe_n[1]);
    `CHK("rxd", 1'b1, serial_rxd);
    @(posedge aclk);
    ext_e_val <= 6'h28;
    serial_txd <= 1'b1;
    cyc(4);
    `CHK("rxd", 1'b0, serial_rxd);
    `CHK("tx out", 1'b1, pe_out[0]);
    rchk("pe pins", PDEG_PE_DATA_ADDR, 32'h29);
    serial_module_enable <= 1'b0;
    cyc(4);
    `CHK("pe_oe_n", 6'h3F, pe_oe_n);
    `CHK("rxd idle", 1'b1, serial_rxd);
  endtask : t_serial
  task automatic t_spi();
    ext_d_en <= 8'hFE;
    ext_d_val <= 8'h08;
    spi_pin_out <= 4'h0;
    spi_pin_drive <= 4'h1;
    spi_pin_own <= 4'h1;
    cyc(5);
    `CHK("pd_oe_n", 8'hFE, pd_oe_n);
    `CHK("pd_out", 8'h00, pd_out);
    `CHK("spi in", 4'h8, spi_pin_in);
    rchk("pd pins", PDEG_PD_DATA_ADDR, 32'h08);
    spi_pin_own <= 4'h0;
    cyc(3);
    `CHK("pd_oe_n", 8'hFF, pd_oe_n);
  endtask : t_spi
  task automatic t_unmapped();
    logic [31:0] d;
    logic [1:0] r;
    wr(8'h04, 8'hFF, r);
    `CHK("bresp", PDEG_RESP_SLVERR, r);
    rd(8'h04, d, r);
    `CHK("rresp", PDEG_RESP_SLVERR, r);
    `CHK("rdata", 32'h0, d);
    // Strobe off: accepted with OKAY but the register keeps its value
    wstrb <= 4'h0;
    wr(PDEG_PD_DIR_ADDR, 8'hFF, r);
    wstrb <= 4'hF;
    `CHK("bresp", PDEG_RESP_OKAY, r);
    rchk("pd dir", PDEG_PD_DIR_ADDR, 32'h0);
  endtask : t_unmapped
  task automatic t_keep();
    wchk(PDEG_PD_DIR_ADDR, 8'hFF);
    wchk(PDEG_PE_DIR_ADDR, 8'hFF);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    cyc(1);
    `CHK("pd_oe_n", 8'hFF, pd_oe_n);
    `CHK("pe_oe_n", 6'h3F, pe_oe_n);
    rchk("pd dir", PDEG_PD_DIR_ADDR, 32'h0);
    wchk(PDEG_PD_DIR_ADDR, 8'hFF);
    wchk(PDEG_PE_DIR_ADDR, 8'hFF);
    rchk("pd keep", PDEG_PD_DATA_ADDR, 32'h5A);
    rchk("pe keep", PDEG_PE_DATA_ADDR, 32'h3F);
  endtask : t_keep

  // ==========================================================
  // Clock and main sequence
  initial begin
    forever #4 aclk = ~aclk;
  end
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_port_d();
    t_pull();
    t_port_e();
    t_serial();
    t_spi();
    t_unmapped();
    t_keep();
    summarize();
  end
endmodule : pdeg_top_bench
